// *** inc/cft_regs.svh ***
// constants for the flag and cycle timing unit
`ifndef CFT_REGS_SVH
`define CFT_REGS_SVH

// status register layout, bit 5 down to bit 0
`define CFT_H_BIT 5
`define CFT_I_BIT 4
`define CFT_N_BIT 3
`define CFT_Z_BIT 2
`define CFT_V_BIT 1
`define CFT_C_BIT 0
`define CFT_CCR_RST 6'h10

// instruction lengths in clock cycles
`define CFT_CYC_ALU_IMM 4'h2
`define CFT_CYC_ALU_DIR 4'h3
`define CFT_CYC_ALU_EXT 4'h4
`define CFT_CYC_ALU_IDX 4'h5
`define CFT_CYC_RMW_ACC 4'h2
`define CFT_CYC_RMW_EXT 4'h6
`define CFT_CYC_RMW_IDX 4'h7
`define CFT_CYC_WIDE_IMM 4'h3
`define CFT_CYC_WIDE_DIR 4'h4
`define CFT_CYC_WIDE_EXT 4'h5
`define CFT_CYC_WIDE_IDX 4'h6
`define CFT_CYC_BRANCH 4'h4
`define CFT_CYC_BSR 4'h8
`define CFT_CYC_RTI 4'hA
`define CFT_CYC_SWI 4'hC
`define CFT_CYC_WAI 4'h9
`define CFT_CYC_RTS 4'h5
`define CFT_CYC_PSHPUL 4'h4
`define CFT_CYC_PTRADJ 4'h4
`define CFT_CYC_INH 4'h2

// interrupt entry latency after the current instruction
`define CFT_CYC_IRQ 4'hC
`define CFT_CYC_IRQ_WAIT 4'h4

`endif

// *** inc/cft_pkg.sv ***
// types for the flag and cycle timing unit
package cft_pkg;

  typedef enum logic [4:0] {
    CFT_OP_ADD = 5'h00,
    CFT_OP_SUB = 5'h01,
    CFT_OP_LOGIC = 5'h02,
    CFT_OP_NEG = 5'h03,
    CFT_OP_DEC = 5'h04,
    CFT_OP_INC = 5'h05,
    CFT_OP_SHIFT = 5'h06,
    CFT_OP_RMW = 5'h07,
    CFT_OP_INDEX_COMPARE = 5'h08,
    CFT_OP_WIDE_LOAD = 5'h09,
    CFT_OP_STORE = 5'h0A,
    CFT_OP_DECIMAL_ADJUST = 5'h0B,
    CFT_OP_TAP = 5'h0C,
    CFT_OP_RETURN_FROM_INTERRUPT = 5'h0D,
    CFT_OP_SWI = 5'h0E,
    CFT_OP_WAIT_FOR_INTERRUPT = 5'h0F,
    CFT_OP_BRANCH = 5'h10,
    CFT_OP_BRANCH_TO_SUBROUTINE = 5'h11,
    CFT_OP_RTS = 5'h12,
    CFT_OP_PSHPUL = 5'h13,
    CFT_OP_PTRADJ = 5'h14,
    CFT_OP_INHERENT = 5'h15
  } cft_op_t;

  typedef enum logic [2:0] {
    CFT_MODE_INH = 3'h0,
    CFT_MODE_ACCUMULATOR_OPERAND = 3'h1,
    CFT_MODE_IMM = 3'h2,
    CFT_MODE_DIR = 3'h3,
    CFT_MODE_EXT = 3'h4,
    CFT_MODE_IDX = 3'h5,
    CFT_MODE_REL = 3'h6
  } cft_mode_t;

  typedef enum logic [3:0] {
    CFT_ST_IDLE = 4'h1,
    CFT_ST_EXEC = 4'h2,
    CFT_ST_WAIT = 4'h4,
    CFT_ST_INTR = 4'h8
  } cft_state_t;

endpackage

// *** hw/cft_cycle_rom.sv ***
// cycle count lookup per instruction class and addressing mode
`timescale 1ns/1ps
`default_nettype none
`include "cft_regs.svh"
module cft_cycle_rom
  import cft_pkg::*;
#(
  parameter int CW = 4
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire cft_op_t op,
  input wire cft_mode_t mode,
  output logic [CW-1:0] len_ff
);

  logic [CW-1:0] nxt_len;

  always_comb begin
    nxt_len = CW'(`CFT_CYC_INH);
    case (op)
      CFT_OP_ADD, CFT_OP_SUB, CFT_OP_LOGIC: begin
        case (mode)
          CFT_MODE_IMM: nxt_len = CW'(`CFT_CYC_ALU_IMM);
          CFT_MODE_DIR: nxt_len = CW'(`CFT_CYC_ALU_DIR);
          CFT_MODE_EXT: nxt_len = CW'(`CFT_CYC_ALU_EXT);
          CFT_MODE_IDX: nxt_len = CW'(`CFT_CYC_ALU_IDX);
          default: nxt_len = CW'(`CFT_CYC_INH);
        endcase
      end
      CFT_OP_NEG, CFT_OP_DEC, CFT_OP_INC, CFT_OP_SHIFT, CFT_OP_RMW: begin
        case (mode)
          CFT_MODE_EXT: nxt_len = CW'(`CFT_CYC_RMW_EXT);
          CFT_MODE_IDX: nxt_len = CW'(`CFT_CYC_RMW_IDX);
          default: nxt_len = CW'(`CFT_CYC_RMW_ACC);
        endcase
      end
      CFT_OP_INDEX_COMPARE, CFT_OP_WIDE_LOAD, CFT_OP_STORE: begin
        case (mode)
          CFT_MODE_IMM: nxt_len = CW'(`CFT_CYC_WIDE_IMM);
          CFT_MODE_DIR: nxt_len = CW'(`CFT_CYC_WIDE_DIR);
          CFT_MODE_EXT: nxt_len = CW'(`CFT_CYC_WIDE_EXT);
          default: nxt_len = CW'(`CFT_CYC_WIDE_IDX);
        endcase
      end
      CFT_OP_BRANCH: nxt_len = CW'(`CFT_CYC_BRANCH);
      CFT_OP_BRANCH_TO_SUBROUTINE: nxt_len = CW'(`CFT_CYC_BSR);
      CFT_OP_RETURN_FROM_INTERRUPT: nxt_len = CW'(`CFT_CYC_RTI);
      CFT_OP_SWI: nxt_len = CW'(`CFT_CYC_SWI);
      CFT_OP_WAIT_FOR_INTERRUPT: nxt_len = CW'(`CFT_CYC_WAI);
      CFT_OP_RTS: nxt_len = CW'(`CFT_CYC_RTS);
      CFT_OP_PSHPUL: nxt_len = CW'(`CFT_CYC_PSHPUL);
      CFT_OP_PTRADJ: nxt_len = CW'(`CFT_CYC_PTRADJ);
      default: nxt_len = CW'(`CFT_CYC_INH);
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      len_ff <= CW'(`CFT_CYC_INH);
    end else begin
      len_ff <= nxt_len;
    end
  end

endmodule
`default_nettype wire

// *** hw/cft_flag_calc.sv ***
// next status flags from one instruction's results
`timescale 1ns/1ps
`default_nettype none
`include "cft_regs.svh"
module cft_flag_calc
  import cft_pkg::*;
(
  input wire cft_op_t op,
  input wire logic wide,
  input wire logic [5:0] ccr,
  input wire logic [15:0] result,
  input wire logic [15:0] opa,
  input wire logic [7:0] opb,
  input wire logic alu_carry,
  input wire logic alu_half,
  input wire logic [7:0] acc_a,
  input wire logic [7:0] stack_ccr,
  output logic [5:0] flags
);

  logic n_res;
  logic z_res;
  logic [7:0] ms_diff;
  logic v_add;
  logic v_sub;

  assign n_res = wide ? result[15] : result[7];
  assign z_res = wide ? (result == 16'h0000) : (result[7:0] == 8'h00);
  assign v_add = (opa[7] & opb[7] & ~result[7]) |
                 (~opa[7] & ~opb[7] & result[7]);
  assign v_sub = (opa[7] & ~opb[7] & ~result[7]) |
                 (~opa[7] & opb[7] & result[7]);
  // only the high bytes decide overflow on the 16-bit compare
  assign ms_diff = opa[15:8] - opb;

  always_comb begin
    flags = ccr;
    flags[`CFT_N_BIT] = n_res;
    flags[`CFT_Z_BIT] = z_res;
    case (op)
      CFT_OP_ADD: begin
        flags[`CFT_H_BIT] = alu_half;
        flags[`CFT_V_BIT] = v_add;
        flags[`CFT_C_BIT] = alu_carry;
      end
      CFT_OP_SUB: begin
        flags[`CFT_V_BIT] = v_sub;
        flags[`CFT_C_BIT] = alu_carry;
      end
      CFT_OP_LOGIC, CFT_OP_WIDE_LOAD, CFT_OP_STORE: begin
        flags[`CFT_V_BIT] = 1'b0;
      end
      CFT_OP_NEG: begin
        flags[`CFT_V_BIT] = (result[7:0] == 8'h80);
        flags[`CFT_C_BIT] = (result[7:0] != 8'h00);
      end
      CFT_OP_DEC: flags[`CFT_V_BIT] = (opb == 8'h80);
      CFT_OP_INC: flags[`CFT_V_BIT] = (opb == 8'h7F);
      CFT_OP_SHIFT: begin
        flags[`CFT_C_BIT] = alu_carry;
        flags[`CFT_V_BIT] = n_res ^ alu_carry;
      end
      CFT_OP_RMW: begin
        flags[`CFT_V_BIT] = 1'b0;
        flags[`CFT_C_BIT] = alu_carry;
      end
      CFT_OP_INDEX_COMPARE: begin
        flags[`CFT_N_BIT] = result[15];
        flags[`CFT_Z_BIT] = (result == 16'h0000);
        flags[`CFT_V_BIT] = (opa[15] & ~opb[7] & ~ms_diff[7]) |
                            (~opa[15] & opb[7] & ms_diff[7]);
      end
      CFT_OP_DECIMAL_ADJUST: begin
        // a carry already set survives the adjust
        flags[`CFT_C_BIT] = ccr[`CFT_C_BIT] | (opb[7:4] > 4'h9);
      end
      CFT_OP_TAP: flags = acc_a[5:0];
      CFT_OP_RETURN_FROM_INTERRUPT: flags = stack_ccr[5:0];
      default: flags = ccr;
    endcase
  end

endmodule
`default_nettype wire

// *** hw/cft_core.sv ***
// flag update, instruction timing and bus cycle sequencing
//
// Contract
// - affected flags set on true test, else cleared
// - overflow set when result equals 80 hex
// - adjust carry: high digit over nine, sticky
// - overflow set when operand was 80 hex
// - overflow set when operand was 7F hex
// - shift overflow equals negative xor carry
// - index compare overflow from high byte subtract
// - 16-bit negative flag follows bit 15
// - return from interrupt reloads all flags
// - interrupt sets mask; masked wait needs NMI
// - accumulator transfer sets all flags
// - interrupt entry 12 cycles, 4 after wait
// - dual operand: 2,3,4,5 cycles by mode
// - read-modify-write: 2, 6 extended, 7 indexed
// - branch 4, subroutine branch 8, implied table
// - bus outputs defined on every cycle
// - same mode and length, same bus sequence; a store also drives its write in the last cycle
// - status bits H I N Z V C, 5 to 0
`timescale 1ns/1ps
`default_nettype none
`include "cft_regs.svh"
module cft_core
  import cft_pkg::*;
#(
  parameter int CW = 4
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire cft_op_t op_in,
  input wire cft_mode_t mode_in,
  input wire logic wide_in,
  input wire logic store_in,
  input wire logic [15:0] result_in,
  input wire logic [15:0] opa_in,
  input wire logic [7:0] opb_in,
  input wire logic alu_carry_in,
  input wire logic alu_half_in,
  input wire logic [7:0] acc_a_in,
  input wire logic [7:0] stack_ccr_in,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] ea_in,
  input wire logic [7:0] wdata_in,
  input wire logic irq_req,
  input wire logic nmi_req,
  output logic [5:0] ccr_ff,
  output logic busy_ff,
  output logic done_ff,
  output logic irq_entry_ff,
  output logic waiting_ff,
  output logic [15:0] addr_ff,
  output logic [7:0] data_ff,
  output logic valid_memory_access_strobe_ff,
  output logic rw_ff
);

  cft_state_t st_ff;
  cft_state_t nxt_st;
  cft_op_t op_ff;
  cft_mode_t mode_ff;
  logic store_ff;
  logic [5:0] pend_ff;
  logic [5:0] nxt_flags;
  logic [CW-1:0] cyc_ff;
  logic [CW-1:0] irq_len_ff;
  logic [CW-1:0] rom_q;
  logic start_ok;
  logic exec_end;
  logic intr_end;
  logic wake;
  logic take_irq;
  cft_op_t rom_op;
  cft_mode_t rom_mode;

  assign start_ok = start && (st_ff == CFT_ST_IDLE);
  assign exec_end = (st_ff == CFT_ST_EXEC) && (cyc_ff == rom_q);
  assign intr_end = (st_ff == CFT_ST_INTR) && (cyc_ff == irq_len_ff);
  // an asserted mask blocks the maskable request, NMI always wins
  assign take_irq = nmi_req || (irq_req && !ccr_ff[`CFT_I_BIT]);
  assign wake = (st_ff == CFT_ST_WAIT) && take_irq;

  // the start cycle addresses the table directly so its answer is
  // ready in the first execution cycle
  assign rom_op = start_ok ? op_in : op_ff;
  assign rom_mode = start_ok ? mode_in : mode_ff;

  cft_cycle_rom #(
    .CW(CW)
  ) u_rom (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .op(rom_op),
    .mode(rom_mode),
    .len_ff(rom_q)
  );

  cft_flag_calc u_flags (
    .op(op_in),
    .wide(wide_in),
    .ccr(ccr_ff),
    .result(result_in),
    .opa(opa_in),
    .opb(opb_in),
    .alu_carry(alu_carry_in),
    .alu_half(alu_half_in),
    .acc_a(acc_a_in),
    .stack_ccr(stack_ccr_in),
    .flags(nxt_flags)
  );

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      CFT_ST_IDLE: begin
        if (start) begin
          nxt_st = CFT_ST_EXEC;
        end
      end
      CFT_ST_EXEC: begin
        if (exec_end) begin
          if (op_ff == CFT_OP_WAIT_FOR_INTERRUPT) begin
            nxt_st = CFT_ST_WAIT;
          end else if (take_irq) begin
            nxt_st = CFT_ST_INTR;
          end else begin
            nxt_st = CFT_ST_IDLE;
          end
        end
      end
      CFT_ST_WAIT: begin
        if (wake) begin
          nxt_st = CFT_ST_INTR;
        end
      end
      CFT_ST_INTR: begin
        if (intr_end) begin
          nxt_st = CFT_ST_IDLE;
        end
      end
      default: nxt_st = CFT_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= CFT_ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // instruction capture; flags are worked out while operands stand
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_ff <= CFT_OP_INHERENT;
      mode_ff <= CFT_MODE_INH;
      store_ff <= 1'b0;
      pend_ff <= `CFT_CCR_RST;
    end else if (start_ok) begin
      op_ff <= op_in;
      mode_ff <= mode_in;
      store_ff <= store_in;
      pend_ff <= nxt_flags;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_ff <= '0;
      irq_len_ff <= CW'(`CFT_CYC_IRQ);
    end else if (start_ok) begin
      cyc_ff <= CW'(1);
    end else if (exec_end && op_ff != CFT_OP_WAIT_FOR_INTERRUPT &&
                 take_irq) begin
      cyc_ff <= CW'(1);
      irq_len_ff <= CW'(`CFT_CYC_IRQ);
    end else if (wake) begin
      cyc_ff <= CW'(1);
      irq_len_ff <= CW'(`CFT_CYC_IRQ_WAIT);
    end else if (st_ff == CFT_ST_EXEC || st_ff == CFT_ST_INTR) begin
      cyc_ff <= cyc_ff + CW'(1);
    end
  end

  // status register, bits H I N Z V C from 5 down to 0
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ccr_ff <= `CFT_CCR_RST;
    end else if (intr_end) begin
      ccr_ff[`CFT_I_BIT] <= 1'b1;
    end else if (exec_end) begin
      ccr_ff <= pend_ff;
      if (op_ff == CFT_OP_SWI) begin
        ccr_ff[`CFT_I_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      irq_entry_ff <= 1'b0;
      waiting_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_st != CFT_ST_IDLE);
      done_ff <= exec_end;
      irq_entry_ff <= intr_end;
      waiting_ff <= (nxt_st == CFT_ST_WAIT);
    end
  end

  // bus shows cycle k of the instruction one clock after cyc_ff is k;
  // every class of one mode and length walks the same pattern, bar the store write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_ff <= 16'h0000;
      data_ff <= 8'h00;
      valid_memory_access_strobe_ff <= 1'b0;
      rw_ff <= 1'b1;
    end else begin
      addr_ff <= pc_in;
      data_ff <= 8'h00;
      valid_memory_access_strobe_ff <= 1'b0;
      rw_ff <= 1'b1;
      if (st_ff == CFT_ST_EXEC) begin
        valid_memory_access_strobe_ff <= 1'b1;
        if (cyc_ff == CW'(2)) begin
          addr_ff <= pc_in + 16'h0001;
        end else if (cyc_ff > CW'(2)) begin
          addr_ff <= ea_in;
        end
        if (mode_ff == CFT_MODE_IDX &&
            (cyc_ff == CW'(3) || cyc_ff == CW'(4))) begin
          valid_memory_access_strobe_ff <= 1'b0;
        end
        if (store_ff && cyc_ff == rom_q) begin
          rw_ff <= 1'b0;
          data_ff <= wdata_in;
        end
      end
    end
  end

  a_tap_flags: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start_ok && op_in == CFT_OP_TAP |=> pend_ff == $past(acc_a_in[5:0]))
    else $error("accumulator transfer flags wrong");

  a_rti_flags: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start_ok && op_in == CFT_OP_RETURN_FROM_INTERRUPT
    |=> pend_ff == $past(stack_ccr_in[5:0]))
    else $error("return flags not from stack");

  a_neg_ovf: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start_ok && op_in == CFT_OP_NEG
    |=> pend_ff[`CFT_V_BIT] == ($past(result_in[7:0]) == 8'h80))
    else $error("negate overflow wrong");

  a_shift_ovf: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start_ok && op_in == CFT_OP_SHIFT
    |=> pend_ff[`CFT_V_BIT] == (pend_ff[`CFT_N_BIT] ^ pend_ff[`CFT_C_BIT]))
    else $error("shift overflow not n xor c");

  a_wide_neg: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start_ok && op_in == CFT_OP_INDEX_COMPARE
    |=> pend_ff[`CFT_N_BIT] == $past(result_in[15]))
    else $error("wide negative flag wrong");

  a_daa_carry: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start_ok && op_in == CFT_OP_DECIMAL_ADJUST && ccr_ff[`CFT_C_BIT]
    |=> pend_ff[`CFT_C_BIT])
    else $error("adjust dropped carry");

  a_commit_flags: assert property (@(posedge ref_clk) disable iff (!arst_n)
    exec_end && op_ff != CFT_OP_SWI
    |=> ccr_ff == $past(pend_ff) && done_ff)
    else $error("flags not committed at end");

  a_irq_mask: assert property (@(posedge ref_clk) disable iff (!arst_n)
    irq_entry_ff |-> ccr_ff[`CFT_I_BIT])
    else $error("mask not set on entry");

  a_masked_wait: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_ff == CFT_ST_WAIT && ccr_ff[`CFT_I_BIT] && !nmi_req
    |=> st_ff == CFT_ST_WAIT)
    else $error("masked wait left without nmi");

  a_wait_latency: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wake |=> (st_ff == CFT_ST_INTR) [*4] ##1 irq_entry_ff)
    else $error("wait wake latency not 4");

  a_alu_ext: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start_ok && op_in == CFT_OP_ADD && mode_in == CFT_MODE_EXT
    |=> rom_q == CW'(4))
    else $error("dual operand extended not 4");

  a_rmw_idx: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start_ok && op_in == CFT_OP_INC && mode_in == CFT_MODE_IDX
    |=> (st_ff == CFT_ST_EXEC) [*7] ##1 done_ff)
    else $error("indexed rmw not 7 cycles");

  a_bsr_len: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start_ok && op_in == CFT_OP_BRANCH_TO_SUBROUTINE |=> rom_q == CW'(8))
    else $error("subroutine branch not 8");

  a_idx_vma: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_ff == CFT_ST_EXEC && mode_ff == CFT_MODE_IDX && cyc_ff == CW'(3)
    |=> !valid_memory_access_strobe_ff [*2])
    else $error("indexed dead cycles strobed");

  a_irq_latency: assert property (@(posedge ref_clk) disable iff (!arst_n)
    exec_end && take_irq && op_ff != CFT_OP_WAIT_FOR_INTERRUPT
    |=> (st_ff == CFT_ST_INTR) [*8] ##1 (st_ff == CFT_ST_INTR) [*4]
    ##1 irq_entry_ff)
    else $error("interrupt entry not 12 cycles");

  a_dec_ovf: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start_ok && op_in == CFT_OP_DEC
    |=> pend_ff[`CFT_V_BIT] == ($past(opb_in) == 8'h80))
    else $error("decrement overflow wrong");

  a_inc_ovf: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start_ok && op_in == CFT_OP_INC
    |=> pend_ff[`CFT_V_BIT] == ($past(opb_in) == 8'h7F))
    else $error("increment overflow wrong");

  a_rmw_ext: assert property (@(posedge ref_clk) disable iff (!arst_n)
    start_ok && op_in == CFT_OP_RMW && mode_in == CFT_MODE_EXT
    |=> rom_q == CW'(6))
    else $error("extended rmw not 6");

  a_bus_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    st_ff != CFT_ST_EXEC
    |=> !valid_memory_access_strobe_ff && rw_ff)
    else $error("bus not idle outside instruction");

  a_store_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
    exec_end && store_ff
    |=> !rw_ff && data_ff == $past(wdata_in))
    else $error("store cycle not driven");

endmodule
`default_nettype wire

// *** verification/cft_bus_mem.sv ***
// memory and peripheral model watching the processor bus
`timescale 1ns/1ps
`default_nettype none
module cft_bus_mem (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] data,
  input wire logic strobe,
  input wire logic rw,
  output logic [15:0] wr_addr_ff,
  output logic [7:0] wr_data_ff,
  output logic [15:0] n_valid_ff
);
  // unstrobed cycles carry dummy addresses, so they are not counted
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      n_valid_ff <= 16'h0000;
    end else if (strobe) begin
      n_valid_ff <= n_valid_ff + 16'h0001;
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_addr_ff <= 16'h0000;
      wr_data_ff <= 8'h00;
    end else if (strobe && !rw) begin
      wr_addr_ff <= addr;
      wr_data_ff <= data;
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the flag and cycle timing core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cft_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  cft_op_t op_in = CFT_OP_INHERENT;
  cft_mode_t mode_in = CFT_MODE_INH;
  logic wide_in = 1'b0;
  logic store_in = 1'b0;
  logic [15:0] result_in = 16'h0000;
  logic [15:0] opa_in = 16'h0000;
  logic [7:0] opb_in = 8'h00;
  logic alu_carry_in = 1'b0;
  logic alu_half_in = 1'b0;
  logic [7:0] acc_a_in = 8'h00;
  logic [7:0] stack_ccr_in = 8'h00;
  logic [15:0] pc_in = 16'h0100;
  logic [15:0] ea_in = 16'h0040;
  logic [7:0] wdata_in = 8'hC3;
  logic irq_req = 1'b0;
  logic nmi_req = 1'b0;
  logic [5:0] ccr_ff;
  logic busy_ff, done_ff, irq_entry_ff, waiting_ff, rw_ff, strobe_ff;
  logic [15:0] addr_ff, wr_addr_ff, n_valid_ff;
  logic [7:0] data_ff, wr_data_ff;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int cnt;
  logic [15:0] nv;

  cft_core DUT (.ref_clk(ref_clk), .arst_n(arst_n), .start(start),
    .op_in(op_in), .mode_in(mode_in), .wide_in(wide_in),
    .store_in(store_in), .result_in(result_in), .opa_in(opa_in),
    .opb_in(opb_in), .alu_carry_in(alu_carry_in),
    .alu_half_in(alu_half_in), .acc_a_in(acc_a_in),
    .stack_ccr_in(stack_ccr_in), .pc_in(pc_in), .ea_in(ea_in),
    .wdata_in(wdata_in), .irq_req(irq_req), .nmi_req(nmi_req),
    .ccr_ff(ccr_ff), .busy_ff(busy_ff), .done_ff(done_ff),
    .irq_entry_ff(irq_entry_ff), .waiting_ff(waiting_ff),
    .addr_ff(addr_ff), .data_ff(data_ff),
    .valid_memory_access_strobe_ff(strobe_ff), .rw_ff(rw_ff));
  cft_bus_mem mem (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr_ff),
    .data(data_ff), .strobe(strobe_ff), .rw(rw_ff), .wr_addr_ff(wr_addr_ff),
    .wr_data_ff(wr_data_ff), .n_valid_ff(n_valid_ff));

  always #12.5 ref_clk = ~ref_clk;

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    // the whole sequence needs well under a thousand cycles
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic issue(input cft_op_t o, input cft_mode_t m,
                       input logic [15:0] r, input logic [7:0] b);
    @(posedge ref_clk);
    #1;
    op_in = o;
    mode_in = m;
    result_in = r;
    opb_in = b;
    start = 1'b1;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
    cnt = 0;
    nv = n_valid_ff;
    chkb(busy_ff, 1'b1);
  endtask

  // cnt ends as the edge count from take to the done pulse
  task automatic go(input cft_op_t o, input cft_mode_t m,
                    input logic [15:0] r, input logic [7:0] b);
    issue(o, m, r, b);
    while (done_ff !== 1'b1 && cnt < 40) begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
    chkb(busy_ff, 1'b0);
    @(posedge ref_clk);
    #1;
    nv = n_valid_ff - nv;
  endtask

  task automatic count_entry;
    cnt = 0;
    while (irq_entry_ff !== 1'b1 && cnt < 40) begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
  endtask

  task automatic t_lengths;
    cft_op_t ot[15] = '{CFT_OP_ADD, CFT_OP_ADD, CFT_OP_ADD, CFT_OP_ADD,
      CFT_OP_SUB, CFT_OP_LOGIC, CFT_OP_SHIFT, CFT_OP_RMW, CFT_OP_INC,
      CFT_OP_BRANCH, CFT_OP_BRANCH_TO_SUBROUTINE, CFT_OP_RTS,
      CFT_OP_PSHPUL, CFT_OP_PTRADJ, CFT_OP_SWI};
    cft_mode_t mt[15] = '{CFT_MODE_IMM, CFT_MODE_DIR, CFT_MODE_EXT,
      CFT_MODE_IDX, CFT_MODE_EXT, CFT_MODE_IDX,
      CFT_MODE_ACCUMULATOR_OPERAND, CFT_MODE_EXT, CFT_MODE_IDX,
      CFT_MODE_REL, CFT_MODE_REL, CFT_MODE_INH, CFT_MODE_INH,
      CFT_MODE_INH, CFT_MODE_INH};
    int nt[15] = '{2, 3, 4, 5, 4, 5, 2, 6, 7, 4, 8, 5, 4, 4, 12};
    for (int i = 0; i < 15; i++) begin
      go(ot[i], mt[i], 16'h0001, 8'h01);
      chk(16'(cnt), 16'(nt[i]));
      chk(nv, 16'(nt[i] - (mt[i] == CFT_MODE_IDX ? 2 : 0)));
    end
  endtask

  task automatic t_overflow;
    go(CFT_OP_NEG, CFT_MODE_ACCUMULATOR_OPERAND, 16'h0080, 8'h80);
    chkb(ccr_ff[1], 1'b1);
    chkb(ccr_ff[3], 1'b1);
    go(CFT_OP_NEG, CFT_MODE_ACCUMULATOR_OPERAND, 16'h007F, 8'h81);
    chkb(ccr_ff[1], 1'b0);
    go(CFT_OP_DEC, CFT_MODE_ACCUMULATOR_OPERAND, 16'h007F, 8'h80);
    chkb(ccr_ff[1], 1'b1);
    go(CFT_OP_DEC, CFT_MODE_ACCUMULATOR_OPERAND, 16'h0080, 8'h81);
    chkb(ccr_ff[1], 1'b0);
    go(CFT_OP_INC, CFT_MODE_ACCUMULATOR_OPERAND, 16'h0080, 8'h7F);
    chkb(ccr_ff[1], 1'b1);
    alu_carry_in = 1'b0;
    go(CFT_OP_SHIFT, CFT_MODE_ACCUMULATOR_OPERAND, 16'h0080, 8'h40);
    chkb(ccr_ff[1], 1'b1);
    alu_carry_in = 1'b1;
    go(CFT_OP_SHIFT, CFT_MODE_ACCUMULATOR_OPERAND, 16'h0080, 8'hC0);
    chkb(ccr_ff[1], 1'b0);
    alu_carry_in = 1'b0;
    opa_in = 16'h8000;
    go(CFT_OP_INDEX_COMPARE, CFT_MODE_IMM, 16'h7F00, 8'h01);
    chkb(ccr_ff[1], 1'b1);
    opa_in = 16'h1000;
    go(CFT_OP_INDEX_COMPARE, CFT_MODE_IMM, 16'h0F00, 8'h01);
    chkb(ccr_ff[1], 1'b0);
    wide_in = 1'b1;
    go(CFT_OP_WIDE_LOAD, CFT_MODE_IMM, 16'h8000, 8'h00);
    chkb(ccr_ff[3], 1'b1);
    go(CFT_OP_WIDE_LOAD, CFT_MODE_IMM, 16'h0080, 8'h00);
    chkb(ccr_ff[3], 1'b0);
    wide_in = 1'b0;
  endtask

  task automatic tap(input logic [7:0] a);
    acc_a_in = a;
    go(CFT_OP_TAP, CFT_MODE_INH, 16'h0000, 8'h00);
  endtask

  task automatic t_loads;
    tap(8'h2A);
    chk(16'(ccr_ff), 16'h002A);
    stack_ccr_in = 8'h15;
    go(CFT_OP_RETURN_FROM_INTERRUPT, CFT_MODE_INH, 16'h0000, 8'h00);
    chk(16'(ccr_ff), 16'h0015);
    chk(16'(cnt), 16'h000A);
    tap(8'h00);
    go(CFT_OP_DECIMAL_ADJUST, CFT_MODE_INH, 16'h0000, 8'hA0);
    chkb(ccr_ff[0], 1'b1);
    tap(8'h00);
    go(CFT_OP_DECIMAL_ADJUST, CFT_MODE_INH, 16'h0012, 8'h12);
    chkb(ccr_ff[0], 1'b0);
    tap(8'h01);
    go(CFT_OP_DECIMAL_ADJUST, CFT_MODE_INH, 16'h0012, 8'h12);
    chkb(ccr_ff[0], 1'b1);
  endtask

  task automatic t_store;
    store_in = 1'b1;
    go(CFT_OP_STORE, CFT_MODE_DIR, 16'h0000, 8'h00);
    store_in = 1'b0;
    chk(16'(cnt), 16'h0004);
    chk(wr_addr_ff, 16'h0040);
    chk({8'h00, wr_data_ff}, 16'h00C3);
  endtask

  // a masked irq must not end the wait, an nmi must
  task automatic wake(input logic masked);
    tap(masked ? 8'h10 : 8'h00);
    issue(CFT_OP_WAIT_FOR_INTERRUPT, CFT_MODE_INH, 16'h0000, 8'h00);
    while (waiting_ff !== 1'b1 && cnt < 40) begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
    chk(16'(cnt), 16'h0009);
    irq_req = 1'b1;
    if (masked) begin
      repeat (10) @(posedge ref_clk);
      #1;
      chkb(waiting_ff, 1'b1);
      chkb(irq_entry_ff, 1'b0);
      nmi_req = 1'b1;
    end
    count_entry();
    irq_req = 1'b0;
    nmi_req = 1'b0;
    chk(16'(cnt), 16'h0005);
    chkb(ccr_ff[4], 1'b1);
  endtask

  task automatic t_irq;
    tap(8'h00);
    irq_req = 1'b1;
    issue(CFT_OP_ADD, CFT_MODE_IMM, 16'h0001, 8'h01);
    count_entry();
    irq_req = 1'b0;
    chk(16'(cnt), 16'h000E);
    chkb(ccr_ff[4], 1'b1);
    wake(1'b0);
    wake(1'b1);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    #1;
    chk(16'(ccr_ff), 16'h0010);
    chkb(rw_ff, 1'b1);
    arst_n = 1'b1;
    t_lengths();
    t_overflow();
    t_loads();
    t_store();
    t_irq();
    end_of_test();
  end
endmodule
`default_nettype wire
